/* File: src/cfgio_port.sv */
// configurable i/o port: register file, pin synchronisers, shared reset pin
// assumes a single-cycle strobe register port from the cpu and board pins
//
// Contract
// R1: up to 26 single-bit pins in four ports, each bit reachable.
// R2: data write loads latches; data read returns pin levels.
// R3: two mode bits per pin: quasi, push-pull, input-only, open-drain.
// R4: every reset leaves each configurable pin input-only.
// R5: modes per pin, except shared reset pin without four modes.
// R6: quasi mode very weak pull-up on while latch holds one.
// R7: quasi mode weak pull-up on only while pin level is one.
// R8: quasi mode latch rising turns strong pull-up on two clocks.
// R9: quasi mode latch zero drives pin strongly low.
// R10: push-pull pulls low like quasi, strong pull-up while latch one.
// R11: input-only disables every driver of the pin.
// R12: open-drain no pull-ups; pulls low only when latch zero.
// R13: board holds floating input and open-drain pins at defined level.
// R14: per-pin select between ttl and schmitt input.
// R15: per-pin slew select, slow by default, set gives fast.
// R16: fuse zero: shared pin schmitt input-only, pull-up from enable bit.
// R17: fuse unprogrammed: shared pin is reset, reads zero, pull-up on.
// R18: read-modify-write of a port reads latch, not pin.
// R19: latches and configuration update at the edge of the write.
`timescale 1ns/1ns
module cfgio_port
	import cfgio_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic rd_latch,
	output logic [7:0] rdata,
	input wire logic [NSLOT-1:0] pin_level,
	input wire logic shared_level,
	input wire logic [7:0] config_fuse_byte,
	output cfgio_drv_t [NSLOT-1:0] pin_drv,
	output logic shared_pullup,
	output logic shared_schmitt,
	output logic shared_reset_req,
	output logic shared_pin_avail
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic cfgio_dec_t decode(input logic [ADDR_W-1:0] a);
		cfgio_dec_t d;
		d.kind = K_NONE;
		d.idx = IDX_P0;
		if (a == A_PORT0) begin
			d.kind = K_DATA;
		end else if (a == A_PORT1) begin
			d.kind = K_DATA;
			d.idx = IDX_P1;
		end else if (a == A_PORT2) begin
			d.kind = K_P2DATA;
		end else if (a == A_PORT3) begin
			d.kind = K_DATA;
			d.idx = IDX_P3;
		end else if (a == A_P0MA) begin
			d.kind = K_MA;
		end else if (a == A_P0MB) begin
			d.kind = K_MB;
		end else if (a == A_P1MA) begin
			d.kind = K_MA;
			d.idx = IDX_P1;
		end else if (a == A_P1MB) begin
			d.kind = K_MB;
			d.idx = IDX_P1;
		end else if (a == A_P3MA) begin
			d.kind = K_MA;
			d.idx = IDX_P3;
		end else if (a == A_P3MB) begin
			d.kind = K_MB;
			d.idx = IDX_P3;
		end else if (a == A_P0SEL) begin
			d.kind = K_SEL;
		end else if (a == A_P1SEL) begin
			d.kind = K_SEL;
			d.idx = IDX_P1;
		end else if (a == A_P3SEL) begin
			d.kind = K_SEL;
			d.idx = IDX_P3;
		end else if (a == A_P2CFG) begin
			d.kind = K_P2CFG;
		end else if (a == A_P0SLEW) begin
			d.kind = K_SLEW;
		end else if (a == A_P1SLEW) begin
			d.kind = K_SLEW;
			d.idx = IDX_P1;
		end else if (a == A_P3SLEW) begin
			d.kind = K_SLEW;
			d.idx = IDX_P3;
		end
		return d;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [NSLOT-1:0] level_meta;
	logic [NSLOT-1:0] level_sync;
	logic shared_meta;
	logic shared_sync;
	logic fuse_meta;
	logic fuse_sync;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level_meta <= '0;
			level_sync <= '0;
		end else begin
			level_meta <= pin_level;
			level_sync <= level_meta;
		end
	end

	// idle level of the reset pin, so no false request follows reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shared_meta <= RST_SHARED_LEVEL;
			shared_sync <= RST_SHARED_LEVEL;
		end else begin
			shared_meta <= shared_level;
			shared_sync <= shared_meta;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fuse_meta <= RST_FUSE_BIT;
			fuse_sync <= RST_FUSE_BIT;
		end else begin
			fuse_meta <= config_fuse_byte[FUSE_RST_BIT];
			fuse_sync <= fuse_meta;
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [NPORT-1:0][7:0] latch;
	logic [NPORT-1:0][7:0] mode_a;
	logic [NPORT-1:0][7:0] mode_b;
	logic [NPORT-1:0][7:0] in_sel;
	logic [NPORT-1:0][7:0] slew;
	logic pullup_en;
	logic [NPORT-1:0][7:0] next_latch;
	logic [NPORT-1:0][7:0] next_mode_a;
	logic [NPORT-1:0][7:0] next_mode_b;
	logic [NPORT-1:0][7:0] next_in_sel;
	logic [NPORT-1:0][7:0] next_slew;
	logic next_pullup_en;
	logic [7:0] next_rdata;
	logic [7:0] wmask;
	logic [7:0] pins;
	cfgio_dec_t dec;
	logic fuse_unprog;

	always_comb begin
		dec = decode(addr);
		wmask = PORT_MASK[dec.idx] & wdata;
		fuse_unprog = (fuse_sync == FUSE_UNPROG);
		next_latch = latch;
		next_mode_a = mode_a;
		next_mode_b = mode_b;
		next_in_sel = in_sel;
		next_slew = slew;
		next_pullup_en = pullup_en;
		if (wr) begin
			case (dec.kind) // see R19
				K_DATA: begin
					next_latch[dec.idx] = wmask; // see R2
				end
				K_MA: begin
					next_mode_a[dec.idx] = wmask; // see R5
				end
				K_MB: begin
					next_mode_b[dec.idx] = wmask; // see R5
				end
				K_SEL: begin
					next_in_sel[dec.idx] = wmask; // see R14
				end
				K_SLEW: begin
					next_slew[dec.idx] = wmask; // see R15
				end
				K_P2CFG: begin
					next_pullup_en = wdata[PULLUP_BIT]; // see R16
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_comb begin
		pins = level_sync[dec.idx*PORT_W +: PORT_W] & PORT_MASK[dec.idx];
		next_rdata = RD_ZERO;
		if (rd) begin
			case (dec.kind)
				K_DATA: begin
					next_rdata = rd_latch ? latch[dec.idx] : pins; // see R2 R18
				end
				K_MA: begin
					next_rdata = mode_a[dec.idx];
				end
				K_MB: begin
					next_rdata = mode_b[dec.idx];
				end
				K_SEL: begin
					next_rdata = in_sel[dec.idx];
				end
				K_SLEW: begin
					next_rdata = slew[dec.idx];
				end
				K_P2DATA: begin
					next_rdata[0] = ~fuse_unprog & shared_sync; // see R17
				end
				K_P2CFG: begin
					next_rdata[PULLUP_BIT] = pullup_en;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latch <= RST_LATCH;
			mode_a <= RST_MODE_A; // see R4
			mode_b <= RST_ZERO; // see R4
			in_sel <= RST_ZERO;
			slew <= RST_ZERO; // see R15
			pullup_en <= RST_SHARED_PULLUP;
		end else begin
			latch <= next_latch;
			mode_a <= next_mode_a;
			mode_b <= next_mode_b;
			in_sel <= next_in_sel;
			slew <= next_slew;
			pullup_en <= next_pullup_en;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= RD_ZERO;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// shared reset pin
	// ------------------------------------------------------------
	logic next_shared_pullup;
	logic next_shared_reset_req;
	logic next_shared_pin_avail;

	always_comb begin
		next_shared_pullup = fuse_unprog | pullup_en; // see R16 R17
		next_shared_reset_req = fuse_unprog & ~shared_sync; // see R17
		next_shared_pin_avail = ~fuse_unprog; // see R16
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shared_pullup <= 1'b1;
			shared_schmitt <= 1'b1;
			shared_reset_req <= 1'b0;
			shared_pin_avail <= 1'b0;
		end else begin
			shared_pullup <= next_shared_pullup;
			shared_schmitt <= 1'b1; // see R16
			shared_reset_req <= next_shared_reset_req;
			shared_pin_avail <= next_shared_pin_avail;
		end
	end

	// ------------------------------------------------------------
	// per-pin drivers
	// ------------------------------------------------------------
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		for (genvar b = 0; b < PORT_W; b++) begin : g_bit
			if (PORT_MASK[p][b]) begin : g_pin
				cfgio_ctrl_t ctrl;
				assign ctrl = '{latch: latch[p][b], mode_a: mode_a[p][b],
					mode_b: mode_b[p][b], schmitt: in_sel[p][b], fast: slew[p][b]};
				cfgio_pin u_pin (
					.clk(clk),
					.rstn(rstn),
					.ctrl(ctrl),
					.level(level_sync[p*PORT_W+b]),
					.drv(pin_drv[p*PORT_W+b])
				); // see R1 R5
			end else begin : g_none
				cfgio_drv_t idle_drv;
				always_ff @(posedge clk or negedge rstn) begin
					if (!rstn) begin
						idle_drv <= DRV_OFF;
					end else begin
						idle_drv <= DRV_OFF;
					end
				end
				assign pin_drv[p*PORT_W+b] = idle_drv;
			end
		end
	end

endmodule

/* File: shared/cfgio_pkg.sv */
// configurable i/o port: register map, reset values, mode codes, carriers
// assumes the cpu clock runs at 100 mhz and drives every register of the block
package cfgio_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int MAX_PINS = 26;
	localparam int NPORT = 3;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 8;
	localparam int NSLOT = NPORT * PORT_W;
	localparam logic [1:0] IDX_P0 = 2'h0;
	localparam logic [1:0] IDX_P1 = 2'h1;
	localparam logic [1:0] IDX_P3 = 2'h2;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_PORT0 = 8'h80;
	localparam logic [7:0] A_PORT1 = 8'h90;
	localparam logic [7:0] A_PORT2 = 8'hA0;
	localparam logic [7:0] A_PORT3 = 8'hB0;
	localparam logic [7:0] A_P0MA = 8'hB1;
	localparam logic [7:0] A_P0MB = 8'hB2;
	localparam logic [7:0] A_P1MA = 8'hB3;
	localparam logic [7:0] A_P1MB = 8'hB4;
	localparam logic [7:0] A_P3MA = 8'hC1;
	localparam logic [7:0] A_P3MB = 8'hC2;
	localparam logic [7:0] A_P0SEL = 8'hC3;
	localparam logic [7:0] A_P1SEL = 8'hC4;
	localparam logic [7:0] A_P2CFG = 8'hC5;
	localparam logic [7:0] A_P3SEL = 8'hC6;
	localparam logic [7:0] A_P0SLEW = 8'hC7;
	localparam logic [7:0] A_P1SLEW = 8'hC8;
	localparam logic [7:0] A_P3SLEW = 8'hC9;

	// ------------------------------------------------------------
	// field layout and reset values, index 2 is port 3
	// ------------------------------------------------------------
	localparam logic [NPORT-1:0][7:0] PORT_MASK = {8'h01, 8'hFF, 8'hFF};
	localparam logic [NPORT-1:0][7:0] RST_LATCH = {8'h01, 8'hFF, 8'hFF};
	localparam logic [NPORT-1:0][7:0] RST_MODE_A = {8'h01, 8'hFF, 8'hFF};
	localparam logic [NPORT-1:0][7:0] RST_ZERO = {8'h00, 8'h00, 8'h00};
	localparam logic RST_SHARED_PULLUP = 1'b0;
	localparam logic RST_FUSE_BIT = 1'b1;
	localparam logic RST_SHARED_LEVEL = 1'b1;
	localparam logic RST_PIN_LATCH = 1'b1;
	localparam int FUSE_RST_BIT = 2;
	localparam int PULLUP_BIT = 7;
	localparam logic FUSE_UNPROG = 1'b1;
	localparam logic [7:0] RD_ZERO = 8'h00;

	// ------------------------------------------------------------
	// mode codes {mode_select_a, mode_select_b}
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_QUASI = 2'b00;
	localparam logic [1:0] MODE_PUSH = 2'b01;
	localparam logic [1:0] MODE_INPUT = 2'b10;
	localparam logic [1:0] MODE_OPEN = 2'b11;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STRONG_PULL_CLK = 2;
	localparam int CNT_W = 2;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		K_NONE, K_DATA, K_MA, K_MB, K_SEL, K_SLEW, K_P2DATA, K_P2CFG
	} cfgio_kind_t;

	typedef struct packed {
		cfgio_kind_t kind;
		logic [1:0] idx;
	} cfgio_dec_t;

	typedef struct packed {
		logic latch;
		logic mode_a;
		logic mode_b;
		logic schmitt;
		logic fast;
	} cfgio_ctrl_t;

	typedef struct packed {
		logic drive_lo;
		logic strong_hi;
		logic weak_hi;
		logic very_weak_hi;
		logic schmitt;
		logic fast_slew;
	} cfgio_drv_t;

	localparam cfgio_drv_t DRV_OFF = '0;

endpackage

/* File: src/cfgio_pin.sv */
// configurable i/o port: driver control of one pin
// assumes ctrl comes from registers on clk and level is already synchronised
`timescale 1ns/1ns
module cfgio_pin
	import cfgio_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input cfgio_ctrl_t ctrl,
	input wire logic level,
	output cfgio_drv_t drv
);

	logic latch_q;
	logic [CNT_W-1:0] cnt;
	logic next_latch_q;
	logic [CNT_W-1:0] next_cnt;
	cfgio_drv_t next_drv;
	logic [1:0] mode;
	logic quasi;
	logic push;
	logic open;
	logic rise;

	// ------------------------------------------------------------
	// driver decode
	// ------------------------------------------------------------
	always_comb begin
		mode = {ctrl.mode_a, ctrl.mode_b}; // see R3
		quasi = (mode == MODE_QUASI);
		push = (mode == MODE_PUSH);
		open = (mode == MODE_OPEN);
		rise = ctrl.latch & ~latch_q;
		next_latch_q = ctrl.latch;
		next_cnt = '0;
		if (quasi && rise) begin
			next_cnt = CNT_W'(STRONG_PULL_CLK - 1); // see R8
		end else if (quasi && cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
		next_drv = DRV_OFF; // see R11
		next_drv.very_weak_hi = quasi & ctrl.latch; // see R6
		next_drv.weak_hi = quasi & level; // see R7
		next_drv.strong_hi = (quasi & ctrl.latch & (rise | (cnt != '0))) // see R8
			| (push & ctrl.latch); // see R10
		next_drv.drive_lo = (quasi | push | open) & ~ctrl.latch; // see R9 R10 R12
		next_drv.schmitt = ctrl.schmitt; // see R14
		next_drv.fast_slew = ctrl.fast; // see R15
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latch_q <= RST_PIN_LATCH;
			cnt <= '0;
			drv <= DRV_OFF; // see R4
		end else begin
			latch_q <= next_latch_q;
			cnt <= next_cnt;
			drv <= next_drv;
		end
	end

endmodule

/* File: testbench/cfgio_port_sva.sv */
// checker for the configurable i/o port: driver and read-port relations
// assumes it is bound to cfgio_port and sees its ports only
`timescale 1ns/1ns
module cfgio_port_sva
	import cfgio_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input cfgio_drv_t [NSLOT-1:0] pin_drv,
	input wire logic shared_pullup,
	input wire logic shared_schmitt,
	input wire logic shared_reset_req,
	input wire logic shared_pin_avail
);
	cfgio_drv_t d0;
	assign d0 = pin_drv[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	reset_drv_a: assert property ($rose(rstn) |-> pin_drv == '0) else $error("drv on");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == RD_ZERO) else $error("rdata");
	strong_pulse_a: assert property ($rose(d0.strong_hi) && d0.very_weak_hi |->
		##1 d0.strong_hi ##1 !d0.strong_hi) else $error("strong len");
	lo_strong_a: assert property (!(d0.drive_lo && d0.strong_hi)) else $error("fight");
	lo_vweak_a: assert property (d0.drive_lo |-> !d0.very_weak_hi) else $error("vweak");
	weak_gate_a: assert property (d0.weak_hi |-> d0.very_weak_hi || d0.drive_lo)
		else $error("weak");
	unused_slot_a: assert property (pin_drv[NSLOT-1] == DRV_OFF) else $error("slot");
	shared_trig_a: assert property (shared_schmitt) else $error("schmitt");
	pullup_fuse_a: assert property (!shared_pin_avail |-> shared_pullup)
		else $error("pullup");
	reset_avail_a: assert property (shared_reset_req |-> !shared_pin_avail)
		else $error("req");
endmodule

/* File: testbench/cfgio_board.sv */
// board model: resolves each pin from the block's drivers and outside loads
// assumes a pull-up resistor on every line
`timescale 1ns/1ns
module cfgio_board
	import cfgio_pkg::*;
(
	input cfgio_drv_t [NSLOT-1:0] pin_drv,
	input wire logic [NSLOT-1:0] ext_low,
	output logic [NSLOT-1:0] pin_level
);
	always_comb begin
		for (int i = 0; i < NSLOT; i++) begin
			pin_level[i] = !(pin_drv[i].drive_lo || ext_low[i]);
		end
	end
endmodule

/* File: testbench/tb.sv */
// testbench for the configurable i/o port
// assumes checker and board model are compiled first
`timescale 1ns/1ns
module tb
	import cfgio_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_latch = 1'b0;
	logic [7:0] rdata;
	logic [NSLOT-1:0] pin_level;
	logic [NSLOT-1:0] ext_low = '0;
	logic shared_level = 1'b1;
	logic [7:0] fuse = 8'hFF;
	cfgio_drv_t [NSLOT-1:0] pin_drv;
	logic sh_pu, sh_st, sh_req, sh_av;
	wire [7:0] drv0 = {2'b00, pin_drv[0]};
	int err_count = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	cfgio_port i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rd_latch(rd_latch), .rdata(rdata), .pin_level(pin_level), .shared_level(shared_level),
		.config_fuse_byte(fuse), .pin_drv(pin_drv), .shared_pullup(sh_pu),
		.shared_schmitt(sh_st), .shared_reset_req(sh_req), .shared_pin_avail(sh_av));
	cfgio_board i_board (.pin_drv(pin_drv), .ext_low(ext_low), .pin_level(pin_level));
	// ------------------------------------------------------------
	// bus and compare
	// ------------------------------------------------------------
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string w, input logic [7:0] a, input logic l, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_latch <= l;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(w, e, rdata);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		wt(1);
		chk("drv0", 8'h00, drv0);
		chk("pullup", 8'h01, {7'h00, sh_pu});
		chk("no req", 8'h00, {7'h00, sh_req});
		rchk("p0 latch", A_PORT0, 1'b1, 8'hFF);
		wreg(A_PORT3, 8'hFF);
		rchk("p3 latch", A_PORT3, 1'b1, 8'h01);
		wreg(8'h10, 8'h55);
		rchk("unmapped", 8'h10, 1'b0, 8'h00);
		rchk("p1 pins", A_PORT1, 1'b0, 8'hFF);
	endtask
	task automatic t_quasi();
		wreg(A_P0MA, 8'h00);
		wt(4);
		chk("quasi hi", 8'h0C, drv0);
		@(posedge clk);
		ext_low[0] <= 1'b1;
		wt(4);
		chk("quasi pulled", 8'h04, drv0);
		rchk("p0 pins", A_PORT0, 1'b0, 8'hFE);
		rchk("p0 latch", A_PORT0, 1'b1, 8'hFF);
		@(posedge clk);
		ext_low[0] <= 1'b0;
		wreg(A_PORT0, 8'hFE);
		wt(4);
		chk("quasi lo", 8'h20, drv0);
		wreg(A_PORT0, 8'hFF);
		wt(1);
		chk("strong c1", 8'h01, {7'h00, pin_drv[0].strong_hi});
		wt(1);
		chk("strong c2", 8'h01, {7'h00, pin_drv[0].strong_hi});
		wt(1);
		chk("strong c3", 8'h00, {7'h00, pin_drv[0].strong_hi});
		wt(3);
		chk("quasi back", 8'h0C, drv0);
	endtask
	task automatic t_modes();
		wreg(A_P0MB, 8'h01);
		wt(3);
		chk("push hi", 8'h10, drv0);
		wreg(A_PORT0, 8'hFE);
		wt(3);
		chk("push lo", 8'h20, drv0);
		wreg(A_PORT0, 8'hFF);
		wreg(A_P0MA, 8'h01);
		wt(3);
		chk("open hi", 8'h00, drv0);
		wreg(A_PORT0, 8'hFE);
		wt(3);
		chk("open lo", 8'h20, drv0);
		wreg(A_P0MB, 8'h00);
		wt(3);
		chk("input", 8'h00, drv0);
		wreg(A_PORT0, 8'hFF);
		wreg(A_P0SEL, 8'h01);
		wreg(A_P0SLEW, 8'h01);
		wreg(A_P3SEL, 8'h01);
		wt(3);
		chk("sel slew", 8'h03, drv0);
		chk("p3 sel", 8'h02, {2'b00, pin_drv[16]});
		chk("p0 bit1", 8'h0C, {2'b00, pin_drv[1]});
	endtask
	task automatic t_fuse();
		@(posedge clk);
		fuse <= 8'hFB;
		wt(5);
		chk("avail", 8'h01, {7'h00, sh_av});
		chk("schmitt", 8'h01, {7'h00, sh_st});
		chk("pu off", 8'h00, {7'h00, sh_pu});
		wreg(A_P2CFG, 8'h80);
		wt(2);
		chk("pu on", 8'h01, {7'h00, sh_pu});
		rchk("p2 pin", A_PORT2, 1'b0, 8'h01);
		@(posedge clk);
		shared_level <= 1'b0;
		fuse <= 8'hFF;
		wt(5);
		chk("rst req", 8'h01, {7'h00, sh_req});
		rchk("p2 zero", A_PORT2, 1'b0, 8'h00);
		wreg(A_P0MA, 8'h00);
		@(posedge clk);
		rstn <= 1'b0;
		wt(3);
		chk("rerst", 8'h00, drv0);
		@(posedge clk);
		rstn <= 1'b1;
		wt(3);
		chk("rerst out", 8'h00, drv0);
	endtask
	// ------------------------------------------------------------
	// run and verdict
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_quasi();
		t_modes();
		t_fuse();
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule
bind cfgio_port cfgio_port_sva i_sva (.clk(clk), .rstn(rstn), .addr(addr), .rd(rd),
	.rdata(rdata), .pin_drv(pin_drv), .shared_pullup(shared_pullup),
	.shared_schmitt(shared_schmitt), .shared_reset_req(shared_reset_req),
	.shared_pin_avail(shared_pin_avail));
